// file: shared/sleep_gate_pkg.sv
// constants and types for the sleep-mode clock gating control block
package sleep_gate_pkg;

    // register byte offsets
    localparam logic [11:0] OFS_SLEEP_GATE   = 12'h110;
    localparam logic [11:0] OFS_IRQ_STATUS   = 12'h1F0;
    localparam logic [11:0] OFS_IRQ_MASK     = 12'h1F4;

    // field positions of the sleep gating register
    localparam int BIT_BUS_CTRL_GATE   = 24;
    localparam int BIT_CONVERTER_GATE  = 16;
    localparam int POS_RATE_LO         = 8;
    localparam int BIT_STANDBY_GATE    = 6;
    localparam int BIT_WATCHDOG_GATE   = 3;

    // writable bits, all others read as zero
    localparam logic [31:0] SLEEP_GATE_WMASK = 32'h0101_0348;
    localparam logic [31:0] SLEEP_GATE_RESET = 32'h0000_0040;
    localparam logic [3:0]  IRQ_MASK_RESET   = 4'h0;

    // unit indices in the per-unit vectors
    localparam int UNIT_WATCHDOG = 0;
    localparam int UNIT_STANDBY  = 1;
    localparam int UNIT_CONV     = 2;
    localparam int UNIT_BUS_CTRL = 3;
    localparam int NUM_UNITS     = 4;

    // converter sample rate codes
    localparam logic [1:0] RATE_125K = 2'h0;
    localparam logic [1:0] RATE_250K = 2'h1;
    localparam logic [1:0] RATE_500K = 2'h2;

    // timing
    localparam int SYS_CLK_HZ   = 50_000_000;
    localparam int RATE_500K_HZ = 500_000;
    localparam int RATE_250K_HZ = 250_000;
    localparam int RATE_125K_HZ = 125_000;
    localparam logic [8:0] CYC_500K = 9'(SYS_CLK_HZ / RATE_500K_HZ);
    localparam logic [8:0] CYC_250K = 9'(SYS_CLK_HZ / RATE_250K_HZ);
    localparam logic [8:0] CYC_125K = 9'(SYS_CLK_HZ / RATE_125K_HZ);

    // avalon response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECODE = 2'h3;

    typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_type;

endpackage

// file: hdl/clock_gate_cell.sv
// latch-based glitch-free clock gate
`timescale 1ns/1ps
module clock_gate_cell (
    input  wire logic clkIn,   // free-running clock
    input  wire logic enable,  // gate enable, same domain
    output wire logic clkOut   // gated clock
);

    logic enLatch;

    // ****************************************
    // enable captured only while clock is low
    // ****************************************
    always_latch begin
        if (!clkIn) begin
            enLatch <= enable;
        end
    end

    assign clkOut = clkIn & enLatch;

endmodule

// file: hdl/sleep_mode_clock_gating_ctrl0.sv
// sleep-mode clock gating control register with gated clocks and faults
//
// Summary of operation
// - each gating bit enables its unit clock when one and stops it when zero.
// - an access to a unit whose clock is gated off raises its unitFault bit and its interrupt status bit.
// - the register resets to 0x00000040, gating bits otherwise off.
// - this register supplies the unit enables only while in sleep mode.
// - sleep values apply only with auto gating selected, else run values.
// - bit 24 is read/write, gates the bus controller, resets to zero.
// - bit 16 is read/write, gates the converter, faults when clear.
// - bits 9:8 pick converter rate 500K, 250K or 125K samples per second.
// - bit 6 is read/write and gates the standby module clock.
// - bit 3 is read/write, gates the watchdog, faults when clear.
// - reserved bits are read-only and read as zero.
// - the register decodes at byte offset 0x110.
`timescale 1ns/1ps
module sleep_mode_clock_gating_ctrl0
    import sleep_gate_pkg::*;
(
    input  wire logic        clk_sys,             // system clock, 50 MHz
    input  wire logic        resetn,              // async reset, active low
    input  wire logic [11:0] avs_address,         // byte address
    input  wire logic        avs_read,            // read request
    input  wire logic        avs_write,           // write request
    input  wire logic [31:0] avs_writedata,       // write data
    input  wire logic [3:0]  avs_byteenable,      // write byte lanes
    output logic      [31:0] avs_readdata,        // read data
    output logic             avs_waitrequest,     // stall request
    output logic      [1:0]  avs_response,        // access response
    input  wire logic        sleepMode,           // system is asleep
    input  wire logic        autoGatingSelect,    // auto gating enabled
    input  wire logic [3:0]  runGateEn,           // run-mode unit enables
    input  wire logic [1:0]  runSampleRate,       // run-mode rate code
    input  wire logic [3:0]  unitAccess,          // access pulse per unit
    output logic      [3:0]  unitFault,           // fault per unit access
    output logic      [3:0]  unitEnable,          // applied unit enables
    output logic      [3:0]  unitClk,             // gated unit clocks
    output logic      [1:0]  converterSampleRate, // applied rate code
    output logic             sampleTick,          // converter sample pulse
    output logic             irq                  // interrupt, active high
);

    // ****************************************
    // functions
    // ****************************************
    function automatic logic [31:0] mergeBytes(
        input logic [31:0] oldVal,
        input logic [31:0] newVal,
        input logic [3:0]  lanes
    );
        logic [31:0] res;
        res = oldVal;
        for (int i = 0; i < 4; i++) begin
            if (lanes[i]) begin
                res[i*8 +: 8] = newVal[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [8:0] rateCycles(input logic [1:0] code);
        logic [8:0] cyc;
        case (code)
            RATE_125K: cyc = CYC_125K;
            RATE_250K: cyc = CYC_250K;
            default:   cyc = CYC_500K; // codes above 500K held at 500K
        endcase
        return cyc;
    endfunction

    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rstPipe_ff;
    logic       rstn;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rstPipe_ff <= 2'b00;
        end else begin
            rstPipe_ff <= {rstPipe_ff[0], 1'b1};
        end
    end

    assign rstn = rstPipe_ff[1];

    // ****************************************
    // bus slave and registers
    // ****************************************
    bus_state_type busState_ff, nxt_busState;
    logic [31:0]   sleepGate_ff, nxt_sleepGate;
    logic [3:0]    irqStatus_ff, nxt_irqStatus;
    logic [3:0]    irqMask_ff, nxt_irqMask;
    logic [31:0]   readData_ff, nxt_readData;
    logic [1:0]    resp_ff, nxt_resp;
    logic [3:0]    faultEvt;
    logic          request;
    logic          doWrite;
    logic          hitSleep;
    logic          hitStatus;
    logic          hitMask;

    assign request   = avs_read | avs_write;
    assign hitSleep  = (avs_address == OFS_SLEEP_GATE);
    assign hitStatus = (avs_address == OFS_IRQ_STATUS);
    assign hitMask   = (avs_address == OFS_IRQ_MASK);
    assign doWrite   = avs_write & (busState_ff == BUS_ANSWER);

    always_comb begin
        nxt_busState  = busState_ff;
        nxt_sleepGate = sleepGate_ff;
        nxt_irqMask   = irqMask_ff;
        nxt_readData  = readData_ff;
        nxt_resp      = resp_ff;
        nxt_irqStatus = irqStatus_ff;
        case (busState_ff)
            BUS_IDLE: begin
                if (request) begin
                    nxt_busState = BUS_ANSWER;
                    nxt_readData = 32'h0000_0000;
                    nxt_resp     = RESP_OKAY;
                    if (hitSleep) begin
                        nxt_readData = sleepGate_ff & SLEEP_GATE_WMASK;
                    end else if (hitStatus) begin
                        nxt_readData = {28'h000_0000, irqStatus_ff};
                    end else if (hitMask) begin
                        nxt_readData = {28'h000_0000, irqMask_ff};
                    end else begin
                        nxt_resp = RESP_DECODE;
                    end
                end
            end
            BUS_ANSWER: begin
                nxt_busState = BUS_IDLE;
                if (doWrite && hitSleep) begin
                    nxt_sleepGate = mergeBytes(sleepGate_ff, avs_writedata,
                                               avs_byteenable)
                                    & SLEEP_GATE_WMASK;
                end
                if (doWrite && hitMask && avs_byteenable[0]) begin
                    nxt_irqMask = avs_writedata[3:0];
                end
                if (doWrite && hitStatus && avs_byteenable[0]) begin
                    nxt_irqStatus = irqStatus_ff & ~avs_writedata[3:0];
                end
            end
            default: begin
                nxt_busState = BUS_IDLE;
            end
        endcase
        // new faults win over a clearing write
        nxt_irqStatus = nxt_irqStatus | faultEvt;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            busState_ff  <= BUS_IDLE;
            sleepGate_ff <= SLEEP_GATE_RESET;
            irqStatus_ff <= 4'h0;
            irqMask_ff   <= IRQ_MASK_RESET;
            readData_ff  <= 32'h0000_0000;
            resp_ff      <= RESP_OKAY;
        end else begin
            busState_ff  <= nxt_busState;
            sleepGate_ff <= nxt_sleepGate;
            irqStatus_ff <= nxt_irqStatus;
            irqMask_ff   <= nxt_irqMask;
            readData_ff  <= nxt_readData;
            resp_ff      <= nxt_resp;
        end
    end

    assign avs_waitrequest = request & (busState_ff == BUS_IDLE);
    assign avs_readdata    = readData_ff;
    assign avs_response    = resp_ff;
    assign irq             = |(irqStatus_ff & irqMask_ff);

    // ****************************************
    // applied enables and gated clocks
    // ****************************************
    logic [3:0] sleepUnits;
    logic [3:0] unitEn_ff, nxt_unitEn;
    logic [1:0] rate_ff, nxt_rate;
    logic       useSleep;

    assign sleepUnits[UNIT_WATCHDOG] = sleepGate_ff[BIT_WATCHDOG_GATE];
    assign sleepUnits[UNIT_STANDBY]  = sleepGate_ff[BIT_STANDBY_GATE];
    assign sleepUnits[UNIT_CONV]     = sleepGate_ff[BIT_CONVERTER_GATE];
    assign sleepUnits[UNIT_BUS_CTRL] = sleepGate_ff[BIT_BUS_CTRL_GATE];

    assign useSleep = sleepMode & autoGatingSelect;

    always_comb begin
        nxt_unitEn = useSleep ? sleepUnits : runGateEn;
        nxt_rate   = useSleep ? sleepGate_ff[POS_RATE_LO +: 2]
                              : runSampleRate;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            unitEn_ff <= 4'h0;
            rate_ff   <= RATE_125K;
        end else begin
            unitEn_ff <= nxt_unitEn;
            rate_ff   <= nxt_rate;
        end
    end

    assign unitEnable          = unitEn_ff;
    assign converterSampleRate = rate_ff;

    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_gate
        clock_gate_cell u_gate (
            .clkIn  (clk_sys),
            .enable (unitEn_ff[u]),
            .clkOut (unitClk[u])
        );
    end

    // ****************************************
    // access faults on gated units
    // ****************************************
    always_comb begin
        faultEvt = unitAccess & ~unitEn_ff;
    end

    assign unitFault = faultEvt;

    // ****************************************
    // converter sample rate divider
    // ****************************************
    logic [8:0] rateCnt_ff, nxt_rateCnt;
    logic       tick_ff, nxt_tick;

    always_comb begin
        nxt_rateCnt = rateCnt_ff + 9'd1;
        nxt_tick    = 1'b0;
        if (!unitEn_ff[UNIT_CONV]) begin
            nxt_rateCnt = 9'd0;
        end else if (rateCnt_ff >= rateCycles(rate_ff) - 9'd1) begin
            nxt_rateCnt = 9'd0;
            nxt_tick    = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rateCnt_ff <= 9'd0;
            tick_ff    <= 1'b0;
        end else begin
            rateCnt_ff <= nxt_rateCnt;
            tick_ff    <= nxt_tick;
        end
    end

    assign sampleTick = tick_ff;

endmodule

// file: dv/sleep_gate_monitor.sv
// port assertions for the sleep gating control block
`timescale 1ns/1ps
module sleep_gate_monitor
    import sleep_gate_pkg::*;
(
    input wire logic        clk_sys,          // clock
    input wire logic        resetn,           // reset
    input wire logic [11:0] avs_address,      // address
    input wire logic        avs_read,         // read
    input wire logic        avs_write,        // write
    input wire logic [31:0] avs_readdata,     // read data
    input wire logic        avs_waitrequest,  // stall
    input wire logic [1:0]  avs_response,     // response
    input wire logic        sleepMode,        // asleep
    input wire logic        autoGatingSelect, // auto gating
    input wire logic [3:0]  runGateEn,        // run enables
    input wire logic [3:0]  unitAccess,       // unit access
    input wire logic [3:0]  unitFault,        // unit fault
    input wire logic [3:0]  unitEnable,       // unit enables
    input wire logic [3:0]  unitClk,          // gated clocks
    input wire logic        sampleTick,       // sample pulse
    input wire logic        irq               // interrupt
);
default clocking @(posedge clk_sys);
endclocking
default disable iff (!resetn);
logic mapped;
assign mapped = avs_address inside {OFS_SLEEP_GATE, OFS_IRQ_STATUS,
                                    OFS_IRQ_MASK};
property p_fault;
    unitFault == (unitAccess & ~unitEnable);
endproperty
a_fault: assert property (p_fault) else $error("fault wrong");
property p_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
endproperty
a_wait: assert property (p_wait) else $error("no answer");
property p_decode;
    avs_read && avs_waitrequest && !mapped |=> !avs_waitrequest
        && avs_response == RESP_DECODE && avs_readdata == 32'h0;
endproperty
a_decode: assert property (p_decode) else $error("bad decode");
property p_okay;
    (avs_read || avs_write) && avs_waitrequest && mapped
        |=> avs_response == RESP_OKAY;
endproperty
a_okay: assert property (p_okay) else $error("bad okay");
property p_resv;
    avs_read && !avs_waitrequest && avs_address == OFS_SLEEP_GATE
        |-> (avs_readdata & ~SLEEP_GATE_WMASK) == 32'h0;
endproperty
a_resv: assert property (p_resv) else $error("reserved set");
property p_run;
    !(sleepMode && autoGatingSelect) && $past(resetn, 3)
        |=> unitEnable == $past(runGateEn);
endproperty
a_run: assert property (p_run) else $error("run enables");
property p_tick;
    sampleTick |=> !sampleTick;
endproperty
a_tick: assert property (p_tick) else $error("tick long");
property p_tick_off;
    !unitEnable[UNIT_CONV] && !$past(unitEnable[UNIT_CONV]) |-> !sampleTick;
endproperty
a_tick_off: assert property (p_tick_off) else $error("tick off");
property p_reset;
    disable iff (1'b0) !resetn |-> unitEnable == 4'h0 && !irq && !sampleTick;
endproperty
a_reset: assert property (p_reset) else $error("reset state");
// while the clock is high each gated clock shows the enable latched low
property p_clk;
    @(negedge clk_sys) unitClk == $past(unitEnable);
endproperty
a_clk: assert property (p_clk) else $error("gated clock");
endmodule
bind sleep_mode_clock_gating_ctrl0 sleep_gate_monitor sleep_gate_monitor_inst (
    .clk_sys, .resetn, .avs_address, .avs_read, .avs_write, .avs_readdata,
    .avs_waitrequest, .avs_response, .sleepMode, .autoGatingSelect,
    .runGateEn, .unitAccess, .unitFault, .unitEnable, .unitClk, .sampleTick,
    .irq
);

// file: dv/test_sleep_mode_clock_gating_ctrl0.sv
// self-checking bench for the sleep gating control block
`timescale 1ns/1ps
module test_sleep_mode_clock_gating_ctrl0
    import sleep_gate_pkg::*;
;
logic        clk_sys = 1'h0;
logic        resetn = 1'h1;
logic [11:0] avs_address = 12'h000;
logic        avs_read = 1'h0;
logic        avs_write = 1'h0;
logic [31:0] avs_writedata = 32'h0;
logic [3:0]  avs_byteenable = 4'hF;
logic [31:0] avs_readdata;
logic        avs_waitrequest;
logic [1:0]  avs_response;
logic        sleepMode = 1'h0;
logic        autoGatingSelect = 1'h0;
logic [3:0]  runGateEn = 4'h0;
logic [1:0]  runSampleRate = 2'h0;
logic [3:0]  unitAccess = 4'h0;
logic [3:0]  unitFault, unitEnable, unitClk;
logic [1:0]  converterSampleRate;
logic        sampleTick, irq;
logic [31:0] q;
logic [1:0]  r;
logic [8:0]  cyc [3] = '{CYC_125K, CYC_250K, CYC_500K};
int          n_fail = 0;
int          cmp_count = 0;
int          per;
always #10 clk_sys = ~clk_sys;
sleep_mode_clock_gating_ctrl0 sleep_mode_clock_gating_ctrl0_inst (
    .clk_sys, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
    .sleepMode, .autoGatingSelect, .runGateEn, .runSampleRate, .unitAccess,
    .unitFault, .unitEnable, .unitClk, .converterSampleRate, .sampleTick,
    .irq
);
task automatic test_done();
    if (n_fail == 0 && cmp_count > 0) begin
        $display("Result: passed");
    end else begin
        $display("Result: failed");
    end
    $finish;
endtask
task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
        n_fail++;
        $display("mismatch %s expected %h seen %h", s, e, g);
    end
endtask
task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'h0) begin
        n++;
        if (n > 50) begin
            n_fail++;
            test_done();
        end
        @(posedge clk_sys);
    end
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
endtask
task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
endtask
task automatic measure();
    int n, k;
    k = 0;
    per = 0;
    for (n = 0; n < 1500 && k < 3; n++) begin
        @(negedge clk_sys);
        if (sampleTick === 1'h1) k++;
        if (k == 2) per++;
    end
    if (k < 3) begin
        n_fail++;
        test_done();
    end
endtask
initial begin
    resetn <= 1'h0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'h1;
    repeat (2) @(posedge clk_sys);
    bus(1'h0, OFS_SLEEP_GATE, 32'h0);
    cmp("reset value", SLEEP_GATE_RESET, q);
    cmp("okay", 32'(RESP_OKAY), 32'(r));
    bus(1'h0, OFS_IRQ_MASK, 32'h0);
    cmp("mask reset", 32'(IRQ_MASK_RESET), q);
    bus(1'h1, OFS_SLEEP_GATE, 32'hFFFF_FFFF);
    bus(1'h0, OFS_SLEEP_GATE, 32'h0);
    cmp("fields", SLEEP_GATE_WMASK, q);
    bus(1'h1, 12'h114, 32'h0);
    cmp("decode", 32'(RESP_DECODE), 32'(r));
    bus(1'h0, 12'h114, 32'h0);
    cmp("unmapped", 32'h0, q);
    bus(1'h0, OFS_SLEEP_GATE, 32'h0);
    cmp("kept", SLEEP_GATE_WMASK, q);
    sleepMode <= 1'h1;
    autoGatingSelect <= 1'h1;
    settle(2);
    cmp("sleep enables", 32'hF, 32'(unitEnable));
    bus(1'h1, OFS_SLEEP_GATE, 32'h0000_0008);
    settle(2);
    cmp("watchdog only", 32'h1, 32'(unitEnable));
    @(posedge clk_sys);
    autoGatingSelect <= 1'h0;
    runGateEn <= 4'h6;
    runSampleRate <= RATE_250K;
    settle(2);
    cmp("run enables", 32'h6, 32'(unitEnable));
    cmp("run rate", 32'(RATE_250K), 32'(converterSampleRate));
    bus(1'h1, OFS_IRQ_MASK, 32'h1);
    unitAccess <= 4'h9;
    @(negedge clk_sys);
    cmp("fault", 32'h9, 32'(unitFault));
    @(posedge clk_sys);
    unitAccess <= 4'h0;
    settle(1);
    cmp("irq on", 32'h1, 32'(irq));
    bus(1'h0, OFS_IRQ_STATUS, 32'h0);
    cmp("status", 32'h9, q);
    bus(1'h1, OFS_IRQ_STATUS, 32'h1);
    settle(1);
    cmp("irq masked", 32'h0, 32'(irq));
    bus(1'h0, OFS_IRQ_STATUS, 32'h0);
    cmp("status left", 32'h8, q);
    autoGatingSelect <= 1'h1;
    for (int c = 0; c < 3; c++) begin
        bus(1'h1, OFS_SLEEP_GATE, 32'h0001_0000 | (32'(c) << POS_RATE_LO));
        measure();
        cmp("period", 32'(cyc[c]), 32'(per));
        cmp("rate", 32'(c), 32'(converterSampleRate));
    end
    test_done();
end
endmodule
